// *** shared/tbpwm_pkg.sv ***
/*
 Constants for the timer based PWM channel: register offsets, field
 positions, reset values and widths.
 Assumes a 32-bit APB slave with one register per aligned word.
*/
package tbpwm_pkg;
    localparam int          DUTY_W        = 10;
    localparam int          REG_W         = 8;
    localparam int          PHASE_W       = 2;
    localparam logic [7:0]  OFS_CONTROL   = 8'h00;
    localparam logic [7:0]  OFS_DUTY_UP   = 8'h04;
    localparam logic [7:0]  OFS_DUTY_LO   = 8'h08;
    localparam logic [7:0]  OFS_PIN_DIR   = 8'h0C;
    localparam int          BIT_ENABLE    = 7;
    localparam int          BIT_LEVEL     = 5;
    localparam int          BIT_INVERT    = 4;
    localparam int          BIT_PIN_INPUT = 0;
    localparam int          DUTY_LO_MSB   = 7;
    localparam int          DUTY_LO_LSB   = 6;
    localparam logic [7:0]  CONTROL_RST   = 8'h00;
    localparam logic        PIN_INPUT_RST = 1'b1;
    localparam logic [31:0] RDATA_ZERO    = 32'h00000000;
    localparam logic [9:0]  DUTY_ZERO     = 10'h000;
endpackage : tbpwm_pkg

// *** design/tbpwm_core.sv ***
/*
 Compare and output stage of the PWM channel: duty buffer, set at
 rollover, clear on duty match, polarity applied last.
 Assumes the base timer count, its prescale phase and the rollover
 pulse come from logic on the same clock.
*/
`timescale 1ns/1ps
module tbpwm_core #(
    parameter int DUTY_BITS = tbpwm_pkg::DUTY_W
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 enable,
    input  wire logic                 invert,
    input  wire logic                 sleep,
    input  wire logic                 rollover,
    input  wire logic [DUTY_BITS-1:0] count10,
    input  wire logic [DUTY_BITS-1:0] duty_next,
    output logic                      level_r
);
    logic [DUTY_BITS-1:0] duty_active_r;
    logic                 raw_r;
    logic                 raw_nxt;

    // Compare width is fixed by the upper/lower register pair
    if (DUTY_BITS != tbpwm_pkg::DUTY_W) begin : g_width_check
        $error("tbpwm_core: duty width must match the register pair");
    end

    // Buffer keeps its value over every reset; only a rollover loads it
    always_ff @(posedge pclk) begin
        if (rollover && !sleep) begin
            duty_active_r <= duty_next;
        end
    end

    always_comb begin
        raw_nxt = raw_r;
        if (!enable) begin
            raw_nxt = 1'b0;
        end else if (sleep) begin
            raw_nxt = raw_r;
        end else if (rollover) begin
            raw_nxt = (duty_next != tbpwm_pkg::DUTY_ZERO);
        end else if (count10 == duty_active_r) begin
            raw_nxt = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            raw_r <= 1'b0;
        end else begin
            raw_r <= raw_nxt;
        end
    end

    // Polarity after the compare, so readback matches the pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_r <= 1'b0;
        end else begin
            level_r <= raw_nxt ^ invert;
        end
    end

    a_disabled_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !enable |=> (raw_r == 1'b0))
        else $error("raw output active while disabled");

    a_polarity_follows: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> (level_r == (raw_r ^ $past(invert))))
        else $error("level does not equal raw output xor polarity");

    a_sleep_holds: assert property (@(posedge pclk) disable iff (!presetn)
        (sleep && enable && $past(enable)) |=> $stable(raw_r))
        else $error("output changed during sleep");

    a_zero_duty_low: assert property (@(posedge pclk) disable iff (!presetn)
        (rollover && !sleep && duty_next == tbpwm_pkg::DUTY_ZERO) |=> !raw_r)
        else $error("zero duty produced an active period start");

    a_rollover_sets: assert property (@(posedge pclk) disable iff (!presetn)
        (rollover && !sleep && enable && duty_next != tbpwm_pkg::DUTY_ZERO) |=> raw_r)
        else $error("output not set at rollover");

    a_match_clears: assert property (@(posedge pclk) disable iff (!presetn)
        (!rollover && !sleep && count10 == duty_active_r) |=> !raw_r)
        else $error("output not cleared on duty match");

    a_buffer_loads: assert property (@(posedge pclk) disable iff (!presetn)
        (!rollover || sleep) |=> $stable(duty_active_r))
        else $error("duty buffer changed outside rollover");
endmodule : tbpwm_core

// *** design/tbpwm_channel.sv ***
/*
 Timer based PWM channel: APB register slave, pin direction control
 and the compare stage. The base timer lives outside.
 Assumes base_timer_count, base_timer_phase and base_timer_rollover
 are driven by the base timer on pclk; rollover is high for the one
 cycle in which the count equals the period limit and the next
 increment clears it.
*/
// How it works
// - Time base runs on pclk; clock changes scale the PWM frequency.
// - Any reset makes the pin an input and resets the control register.
// - Control bit 7 enables the channel when one, disables when zero.
// - Control bit 5 reads the present output level; writes ignored.
// - Control bit 4 set gives an active low output, clear active high.
// - Duty upper register holds the eight high duty bits, read/write.
// - Duty lower bits 7:6 hold low duty bits; bits 5:0 read zero.
// - Control resets to zero; duty registers keep value over resets.
// - Set at timer clear, clear when count equals buffered duty.
// - Duty registers copy into the compare buffer only at period match.
// - Zero duty keeps the output inactive for the whole period.
// - During sleep nothing advances and the output level is held unless control is rewritten.
`timescale 1ns/1ps
module tbpwm_channel #(
    parameter int ADDR_W = 8
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [7:0]        base_timer_count,
    input  wire logic [1:0]        base_timer_phase,
    input  wire logic              base_timer_rollover,
    input  wire logic              sleep,
    output logic                   pwm_level,
    output logic                   pin_out,
    output logic                   pin_oe
);
    logic [7:0]  duty_upper_r;
    logic [1:0]  duty_lower_r;
    logic        channel_enable_r;
    logic        output_invert_r;
    logic        pin_input_r;
    logic        level_r;
    logic [31:0] prdata_r;
    logic [31:0] rdata_nxt;
    logic        pready_r;
    logic        pslverr_r;
    logic        bad_nxt;
    logic        setup;
    logic        wr_take;
    logic [7:0]  ofs;

    // Decoder reads the low eight address bits
    if (ADDR_W < 8) begin : g_addr_check
        $error("tbpwm_channel: address must reach the register map");
    end

    assign setup   = psel && !penable;
    assign wr_take = psel && penable && pready_r && pwrite && !pslverr_r;
    assign ofs     = paddr[7:0];

    always_comb begin
        rdata_nxt = tbpwm_pkg::RDATA_ZERO;
        bad_nxt   = 1'b0;
        case (ofs)
            tbpwm_pkg::OFS_CONTROL: begin
                rdata_nxt[tbpwm_pkg::BIT_ENABLE] = channel_enable_r;
                rdata_nxt[tbpwm_pkg::BIT_LEVEL]  = level_r;
                rdata_nxt[tbpwm_pkg::BIT_INVERT] = output_invert_r;
            end
            tbpwm_pkg::OFS_DUTY_UP: begin
                rdata_nxt[7:0] = duty_upper_r;
            end
            tbpwm_pkg::OFS_DUTY_LO: begin
                rdata_nxt[tbpwm_pkg::DUTY_LO_MSB:tbpwm_pkg::DUTY_LO_LSB] = duty_lower_r;
            end
            tbpwm_pkg::OFS_PIN_DIR: begin
                rdata_nxt[tbpwm_pkg::BIT_PIN_INPUT] = pin_input_r;
            end
            default: begin
                bad_nxt = 1'b1;
            end
        endcase
    end

    // One access cycle answer: data captured in setup, ready in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= tbpwm_pkg::RDATA_ZERO;
        end else begin
            pready_r  <= setup;
            pslverr_r <= setup && bad_nxt;
            if (setup && !pwrite) begin
                prdata_r <= rdata_nxt;
            end else if (!setup) begin
                prdata_r <= tbpwm_pkg::RDATA_ZERO;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_enable_r <= tbpwm_pkg::CONTROL_RST[tbpwm_pkg::BIT_ENABLE];
            output_invert_r  <= tbpwm_pkg::CONTROL_RST[tbpwm_pkg::BIT_INVERT];
        end else if (wr_take && ofs == tbpwm_pkg::OFS_CONTROL) begin
            channel_enable_r <= pwdata[tbpwm_pkg::BIT_ENABLE];
            output_invert_r  <= pwdata[tbpwm_pkg::BIT_INVERT];
        end
    end

    // Duty holds over every reset, so it has no reset branch
    always_ff @(posedge pclk) begin
        if (wr_take && ofs == tbpwm_pkg::OFS_DUTY_UP) begin
            duty_upper_r <= pwdata[7:0];
        end
        if (wr_take && ofs == tbpwm_pkg::OFS_DUTY_LO) begin
            duty_lower_r <= pwdata[tbpwm_pkg::DUTY_LO_MSB:tbpwm_pkg::DUTY_LO_LSB];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_input_r <= tbpwm_pkg::PIN_INPUT_RST;
        end else if (wr_take && ofs == tbpwm_pkg::OFS_PIN_DIR) begin
            pin_input_r <= pwdata[tbpwm_pkg::BIT_PIN_INPUT];
        end
    end

    // Timer count and prescale phase form the pclk-derived 10-bit base
    tbpwm_core #(
        .DUTY_BITS (tbpwm_pkg::DUTY_W)
    ) u_core (
        .pclk      (pclk),
        .presetn   (presetn),
        .enable    (channel_enable_r),
        .invert    (output_invert_r),
        .sleep     (sleep),
        .rollover  (base_timer_rollover),
        .count10   ({base_timer_count, base_timer_phase}),
        .duty_next ({duty_upper_r, duty_lower_r}),
        .level_r   (level_r)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_level <= 1'b0;
            pin_out   <= 1'b0;
            pin_oe    <= 1'b0;
        end else begin
            pwm_level <= level_r;
            pin_out   <= level_r;
            pin_oe    <= !pin_input_r;
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;

    a_pin_follows_level: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> (pin_out == $past(level_r) && pwm_level == $past(level_r)))
        else $error("pin does not follow the channel level");

    a_pin_dir_drive: assert property (@(posedge pclk) disable iff (!presetn)
        pin_input_r |=> !pin_oe)
        else $error("pin driven while direction is input");

    a_enable_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_take && ofs == tbpwm_pkg::OFS_CONTROL)
        |=> (channel_enable_r == $past(pwdata[tbpwm_pkg::BIT_ENABLE])))
        else $error("enable bit did not take the written value");

    a_level_readback: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && ofs == tbpwm_pkg::OFS_CONTROL)
        |=> (prdata_r[tbpwm_pkg::BIT_LEVEL] == $past(level_r)))
        else $error("level readback wrong");

    a_low_duty_zeros: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && ofs == tbpwm_pkg::OFS_DUTY_LO) |=> (prdata_r[5:0] == 6'h00))
        else $error("unimplemented duty bits read nonzero");

    a_ready_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
        setup |=> (pready_r ##1 !pready_r))
        else $error("ready not a single access cycle");
endmodule : tbpwm_channel

// *** tb/tbpwm_timer_model.sv ***
/*
 Model of the shared base timer: 8-bit count, 2-bit prescale phase and
 a one-cycle rollover pulse at the period limit.
 Assumes one clock and a 1:4 prescale; the limit is fixed per run.
*/
`timescale 1ns/1ps
module tbpwm_timer_model #(
    parameter logic [7:0] LIMIT = 8'h07
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       run,
    input  wire logic       sleep,
    output logic      [7:0] count,
    output logic      [1:0] phase,
    output logic            rollover
);
    assign rollover = run && !sleep && count == LIMIT && phase == 2'h3;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 8'h00;
            phase <= 2'h0;
        end else if (run && !sleep) begin
            phase <= phase + 2'h1;
            if (rollover) begin
                count <= 8'h00;
            end else if (phase == 2'h3) begin
                count <= count + 8'h01;
            end
        end
    end
endmodule : tbpwm_timer_model

// *** tb/tbpwm_channel_bench.sv ***
/*
 Self-checking bench for the PWM channel: APB master tasks, one task
 per scenario, high-cycle counts over one 32-cycle period.
 Assumes the timer model with a period limit of 7 and zero wait states.
*/
`timescale 1ns/1ps
module tbpwm_channel_bench;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, run = 1'b0, sleep = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000, prdata, rd;
    logic        pready, pslverr, pwm_level, pin_out, pin_oe, rollover, err;
    logic [7:0]  count;
    logic [1:0]  phase;
    int          fail_count = 0, samples_checked = 0, cyc = 0, hi;

    tbpwm_channel tbpwm_channel_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .base_timer_count(count), .base_timer_phase(phase),
        .base_timer_rollover(rollover), .sleep(sleep), .pwm_level(pwm_level),
        .pin_out(pin_out), .pin_oe(pin_oe));
    tbpwm_timer_model tbpwm_timer_model_i (.pclk(pclk), .presetn(presetn), .run(run),
        .sleep(sleep), .count(count), .phase(phase), .rollover(rollover));

    initial begin
        forever #2.5 pclk = ~pclk;
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : tally_and_finish

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic set_duty(input logic [9:0] d);
        apb(1'b1, tbpwm_pkg::OFS_DUTY_UP, {24'h000000, d[9:2]});
        apb(1'b1, tbpwm_pkg::OFS_DUTY_LO, {24'h000000, d[1:0], 6'h00});
    endtask : set_duty

    // Window starts two edges after rollover to skip the output flop
    task automatic measure;
        hi = 0;
        do @(posedge pclk); while (rollover !== 1'b1);
        @(posedge pclk);
        repeat (32) begin
            @(posedge pclk);
            if (pwm_level === 1'b1) hi++;
        end
    endtask : measure

    task automatic t_regs;
        apb(1'b0, tbpwm_pkg::OFS_CONTROL, 32'h0);
        chk(rd, 32'h00000000);
        apb(1'b0, tbpwm_pkg::OFS_PIN_DIR, 32'h0);
        chk({rd[0], pin_oe}, 2'h2);
        apb(1'b1, tbpwm_pkg::OFS_DUTY_UP, 32'hFFFFFFA5);
        apb(1'b0, tbpwm_pkg::OFS_DUTY_UP, 32'h0);
        chk(rd, 32'h000000A5);
        apb(1'b1, tbpwm_pkg::OFS_DUTY_LO, 32'h000000FF);
        apb(1'b0, tbpwm_pkg::OFS_DUTY_LO, 32'h0);
        chk(rd, 32'h000000C0);
        apb(1'b1, tbpwm_pkg::OFS_CONTROL, 32'h00000020);
        apb(1'b0, tbpwm_pkg::OFS_CONTROL, 32'h0);
        chk(rd, 32'h00000000);
        apb(1'b1, 8'h10, 32'h000000FF);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 8'h10, 32'h0);
        chk({rd[30:0], err}, 32'h1);
    endtask : t_regs

    // Pin kept as input until the first period has run
    task automatic t_setup;
        apb(1'b1, tbpwm_pkg::OFS_PIN_DIR, 32'h1);
        apb(1'b1, tbpwm_pkg::OFS_CONTROL, 32'h0);
        set_duty(10'h00A);
        run <= 1'b1;
        measure();
        apb(1'b1, tbpwm_pkg::OFS_PIN_DIR, 32'h0);
        apb(1'b1, tbpwm_pkg::OFS_CONTROL, 32'h80);
        chk({31'h0, pin_oe}, 32'h1);
    endtask : t_setup

    task automatic t_duty(input logic [7:0] ctl, input logic [9:0] d, input int exp);
        apb(1'b1, tbpwm_pkg::OFS_CONTROL, {24'h0, ctl});
        set_duty(d);
        measure();
        measure();
        chk(hi, exp);
        chk({31'h0, pin_out}, {31'h0, pwm_level});
    endtask : t_duty

    // Mid-period duty write must not reach the running period
    task automatic t_buffer;
        do @(posedge pclk); while (rollover !== 1'b1);
        set_duty(10'h3FF);
        repeat (14) @(posedge pclk);
        chk({31'h0, pwm_level}, 32'h0);
        measure();
        chk(hi, 32);
        set_duty(10'h00A);
    endtask : t_buffer

    // Peripheral-only use: pin stays an input, no wait for a first period
    task automatic t_internal;
        apb(1'b1, tbpwm_pkg::OFS_PIN_DIR, 32'h1);
        apb(1'b1, tbpwm_pkg::OFS_CONTROL, 32'h0);
        set_duty(10'h00A);
        apb(1'b1, tbpwm_pkg::OFS_CONTROL, 32'h80);
        measure();
        chk(hi, 11);
        chk({31'h0, pin_oe}, 32'h0);
    endtask : t_internal

    task automatic t_sleep;
        do @(posedge pclk); while (rollover !== 1'b1);
        repeat (4) @(posedge pclk);
        sleep <= 1'b1;
        repeat (40) @(posedge pclk);
        chk({31'h0, pwm_level}, 32'h1);
        sleep <= 1'b0;
    endtask : t_sleep

    task automatic t_rerun;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        chk({pin_oe, pwm_level}, 2'h0);
        presetn <= 1'b1;
        apb(1'b0, tbpwm_pkg::OFS_CONTROL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, tbpwm_pkg::OFS_DUTY_UP, 32'h0);
        chk(rd, 32'h00000002);
    endtask : t_rerun

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_setup();
        t_duty(8'h80, 10'h00A, 11);
        t_duty(8'h80, 10'h000, 0);
        t_duty(8'h80, 10'h3FF, 32);
        t_duty(8'h90, 10'h00A, 21);
        t_duty(8'h10, 10'h00A, 32);
        apb(1'b0, tbpwm_pkg::OFS_CONTROL, 32'h0);
        chk(rd, 32'h00000030);
        t_duty(8'h00, 10'h00A, 0);
        t_duty(8'h80, 10'h00A, 11);
        t_buffer();
        t_internal();
        t_sleep();
        t_rerun();
        tally_and_finish();
    end
endmodule : tbpwm_channel_bench
